// ### core/sdb_core.v
`timescale 1ns/100ps
`include "sdb_defs.vh"

module sdb_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Fill side
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_clk)
  begin
    if (i_clk_en && push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else if (i_clk_en)
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sdb_fifo

module sdb_core #(
  parameter DATA_W = 16,
  parameter COL_W = 8,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
)
(
  // Clock, reset, freeze
  input wire i_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Command pins
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [11:0] i_addr,
  input wire [1:0] i_bank_select_inputs,
  input wire i_dqm,
  // Data pins
  input wire [DATA_W-1:0] i_dq,
  output reg [DATA_W-1:0] o_dq,
  output reg o_dq_oe,
  // Mode settings
  input wire i_latency_three,
  input wire [2:0] i_burst_len,
  input wire i_interleave,
  input wire i_write_burst_mode_bit,
  // Status
  output reg [3:0] o_bank_open,
  output wire o_wr_buffer_ready
);
  localparam ENTRY_W = 2 + COL_W + DATA_W;
  localparam WORDS = 4 << COL_W;
  localparam [3:0] BANK_OPEN_RST = `SDB_RST_BANK_OPEN;

  // One row per bank is held; row address is not stored
  reg [DATA_W-1:0] mem [0:WORDS-1];

  wire [3:0] cmd;
  wire is_act;
  wire is_pre;
  wire is_read;
  wire is_write;
  wire is_bst;
  wire any_access;
  reg [COL_W-1:0] blk_mask;
  reg [COL_W-1:0] bl_m1;
  reg bl_page;

  // Read engine
  reg rd_active;
  reg rd_page;
  reg rd_ap;
  reg [1:0] rd_bank;
  reg [COL_W-1:0] rd_start;
  reg [COL_W-1:0] rd_k;
  reg [COL_W-1:0] rd_left;
  reg [COL_W-1:0] rd_mask;
  reg rd_il;
  wire rd_stop;
  wire rd_step;
  wire fetch_en;
  wire [COL_W+1:0] fetch_addr;

  // Output pipe
  reg [DATA_W-1:0] st0_data;
  reg st0_v;
  reg [DATA_W-1:0] st1_data;
  reg st1_v;
  reg dqm_d1;
  reg next_v;
  reg [DATA_W-1:0] next_data;

  // Write engine
  reg wr_active;
  reg wr_page;
  reg wr_ap;
  reg [1:0] wr_bank;
  reg [COL_W-1:0] wr_start;
  reg [COL_W-1:0] wr_k;
  reg [COL_W-1:0] wr_left;
  reg [COL_W-1:0] wr_mask;
  reg wr_il;
  wire wr_stop;
  wire wr_step;
  wire cap_en;
  wire [ENTRY_W-1:0] cap_entry;
  wire buf_valid;
  wire buf_ready;
  wire [ENTRY_W-1:0] buf_entry;

  function [COL_W-1:0] col_at;
    input [COL_W-1:0] start;
    input [COL_W-1:0] k;
    input [COL_W-1:0] mask;
    input il;
    begin
      if (il)
      begin
        col_at = start ^ k;
      end
      else
      begin
        col_at = (start & ~mask) | ((start + k) & mask);
      end
    end
  endfunction

  assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign is_act = (cmd == `SDB_CMD_ACTIVATE);
  assign is_pre = (cmd == `SDB_CMD_PRECHARGE);
  assign is_read = (cmd == `SDB_CMD_READ);
  assign is_write = (cmd == `SDB_CMD_WRITE);
  assign is_bst = (cmd == `SDB_CMD_TERMINATE);
  assign any_access = is_read || is_write || is_bst;

  always @*
  begin
    bl_page = 1'b0;
    case (i_burst_len)
      `SDB_BL_2:
      begin
        blk_mask = {{(COL_W-1){1'b0}}, 1'b1};
        bl_m1 = {{(COL_W-1){1'b0}}, 1'b1};
      end
      `SDB_BL_4:
      begin
        blk_mask = {{(COL_W-2){1'b0}}, 2'h3};
        bl_m1 = {{(COL_W-2){1'b0}}, 2'h3};
      end
      `SDB_BL_8:
      begin
        blk_mask = {{(COL_W-3){1'b0}}, 3'h7};
        bl_m1 = {{(COL_W-3){1'b0}}, 3'h7};
      end
      `SDB_BL_PAGE:
      begin
        blk_mask = {COL_W{1'b1}};
        bl_m1 = {COL_W{1'b1}};
        bl_page = 1'b1;
      end
      default:
      begin
        blk_mask = {COL_W{1'b0}};
        bl_m1 = {COL_W{1'b0}};
      end
    endcase
  end

  // New access or terminate ends the running burst; precharge only for its bank or for all banks
  assign rd_stop = any_access || (is_pre && (i_addr[`SDB_AP_BIT] || i_bank_select_inputs == rd_bank));
  assign rd_step = rd_active && !rd_stop;
  assign fetch_en = is_read || rd_step;
  assign fetch_addr = is_read ? {i_bank_select_inputs, i_addr[COL_W-1:0]}
    : {rd_bank, col_at(rd_start, rd_k, rd_mask, rd_il)};

  always @(posedge i_clk)
  begin
    if (i_clk_en && fetch_en)
    begin
      st0_data <= mem[fetch_addr];
    end
  end

  // Array is single ported; reads win and buffered writes wait
  assign buf_ready = !fetch_en;

  always @(posedge i_clk)
  begin
    if (i_clk_en && buf_valid && buf_ready)
    begin
      mem[buf_entry[ENTRY_W-1:DATA_W]] <= buf_entry[DATA_W-1:0];
    end
  end

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rd_active <= 1'b0;
      rd_page <= 1'b0;
      rd_ap <= 1'b0;
      rd_bank <= 2'h0;
      rd_start <= {COL_W{1'b0}};
      rd_k <= {COL_W{1'b0}};
      rd_left <= {COL_W{1'b0}};
      rd_mask <= {COL_W{1'b0}};
      rd_il <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (is_read)
      begin
        rd_active <= bl_page || (bl_m1 != {COL_W{1'b0}});
        rd_page <= bl_page;
        rd_ap <= i_addr[`SDB_AP_BIT];
        rd_bank <= i_bank_select_inputs;
        rd_start <= i_addr[COL_W-1:0];
        rd_k <= {{(COL_W-1){1'b0}}, 1'b1};
        rd_left <= bl_m1;
        rd_mask <= blk_mask;
        rd_il <= i_interleave && !bl_page;
      end
      else if (rd_stop)
      begin
        rd_active <= 1'b0;
      end
      else if (rd_active)
      begin
        rd_k <= rd_k + 1'b1;
        rd_left <= rd_left - 1'b1;
        rd_active <= rd_page || (rd_left != {{(COL_W-1){1'b0}}, 1'b1});
      end
    end
  end

  // Fetch edge counts as latency one; one more stage for three
  always @*
  begin
    next_v = i_latency_three ? st1_v : st0_v;
    next_data = i_latency_three ? st1_data : st0_data;
  end

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st0_v <= 1'b0;
      st1_v <= 1'b0;
      st1_data <= `SDB_RST_WORD;
      dqm_d1 <= 1'b0;
      o_dq <= `SDB_RST_WORD;
      o_dq_oe <= 1'b0;
    end
    else if (i_clk_en)
    begin
      dqm_d1 <= i_dqm;
      st1_data <= st0_data;
      o_dq <= next_data;
      if (is_write)
      begin
        st0_v <= 1'b0;
        st1_v <= 1'b0;
        o_dq_oe <= 1'b0;
      end
      else
      begin
        st0_v <= fetch_en;
        st1_v <= st0_v;
        o_dq_oe <= next_v && !dqm_d1;
      end
    end
  end

  assign wr_stop = any_access || (is_pre && (i_addr[`SDB_AP_BIT] || i_bank_select_inputs == wr_bank));
  assign wr_step = wr_active && !wr_stop;
  // Mask gates capture on the same edge
  assign cap_en = (is_write || wr_step) && !i_dqm;
  assign cap_entry = is_write ? {i_bank_select_inputs, i_addr[COL_W-1:0], i_dq}
    : {wr_bank, col_at(wr_start, wr_k, wr_mask, wr_il), i_dq};

  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_active <= 1'b0;
      wr_page <= 1'b0;
      wr_ap <= 1'b0;
      wr_bank <= 2'h0;
      wr_start <= {COL_W{1'b0}};
      wr_k <= {COL_W{1'b0}};
      wr_left <= {COL_W{1'b0}};
      wr_mask <= {COL_W{1'b0}};
      wr_il <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (is_write)
      begin
        wr_active <= !i_write_burst_mode_bit && (bl_page || (bl_m1 != {COL_W{1'b0}}));
        wr_page <= bl_page;
        wr_ap <= i_addr[`SDB_AP_BIT];
        wr_bank <= i_bank_select_inputs;
        wr_start <= i_addr[COL_W-1:0];
        wr_k <= {{(COL_W-1){1'b0}}, 1'b1};
        wr_left <= bl_m1;
        wr_mask <= blk_mask;
        wr_il <= i_interleave && !bl_page;
      end
      else if (wr_stop)
      begin
        wr_active <= 1'b0;
      end
      else if (wr_active)
      begin
        wr_k <= wr_k + 1'b1;
        wr_left <= wr_left - 1'b1;
        wr_active <= wr_page || (wr_left != {{(COL_W-1){1'b0}}, 1'b1});
      end
    end
  end

  // Word is lost if the buffer is full; the controller sees o_wr_buffer_ready
  sdb_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) sdb_fifo_inst (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_in_valid(cap_en),
    .o_in_ready(o_wr_buffer_ready),
    .i_in_data(cap_entry),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_ready),
    .o_out_data(buf_entry)
  );

  // Row state per bank: activate opens, precharge or auto precharge closes
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_bank
      wire rd_close;
      wire wr_close;
      wire pre_hit;
      // Auto precharge at natural end, or when another access cuts the burst
      assign rd_close = rd_active && rd_ap && (rd_bank == b)
        && (rd_stop || (!rd_page && rd_left == {{(COL_W-1){1'b0}}, 1'b1}));
      assign wr_close = wr_active && wr_ap && (wr_bank == b)
        && (wr_stop || (!wr_page && wr_left == {{(COL_W-1){1'b0}}, 1'b1}));
      assign pre_hit = is_pre && (i_addr[`SDB_AP_BIT] || i_bank_select_inputs == b);
      always @(posedge i_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          o_bank_open[b] <= BANK_OPEN_RST[b];
        end
        else if (i_clk_en)
        begin
          if (is_act && i_bank_select_inputs == b)
          begin
            o_bank_open[b] <= 1'b1;
          end
          else if (pre_hit || rd_close || wr_close
            || (is_read && i_addr[`SDB_AP_BIT] && i_bank_select_inputs == b
              && bl_m1 == {COL_W{1'b0}} && !bl_page)
            || (is_write && i_addr[`SDB_AP_BIT] && i_bank_select_inputs == b
              && (i_write_burst_mode_bit || (bl_m1 == {COL_W{1'b0}} && !bl_page))))
          begin
            o_bank_open[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // sdb_core

// ### include/sdb_defs.vh
// Summary of operation
// - Read carries column, bank, auto-precharge; auto precharge closes the row after the burst.
// - First read word appears one read latency after the command, then one per clock.
// - Data pins float once a read burst ends with no further command.
// - Full-page bursts run until stopped; the column wraps to zero at page end.
// - A new read truncates a read; issued latency minus one before last wanted word.
// - A read command is accepted on any clock after a previous read, any bank.
// - Mask held high three clocks before a write; outputs masked two clocks later.
// - A write truncating a read floats the data pins regardless of the mask.
// - Mask dropped before a write; input data is masked with no delay.
// - Precharge to the same bank ends a read; issued latency minus one before.
// - Burst terminate stops a read; issued latency minus one before last wanted word.
// - Write carries column, bank, auto-precharge; auto precharge closes the row afterwards.
// - First write word captured with the command, then one word per clock.
// - After a fixed write burst ends, pins float and input data is ignored.
// - A write is accepted on any clock after a write; its data belongs to it.
// - A read truncating a write stops capture from the read edge on.
// - Burst terminate in a write ignores its own data; previous word is the last.
// - Read latency is selectable as two or three clocks.
// - Write burst mode bit set makes every write a single-column access.
`ifndef SDB_DEFS_VH
`define SDB_DEFS_VH

// Command code {cs_n, ras_n, cas_n, we_n}
`define SDB_CMD_ACTIVATE 4'h3
`define SDB_CMD_PRECHARGE 4'h2
`define SDB_CMD_READ 4'h5
`define SDB_CMD_WRITE 4'h4
`define SDB_CMD_TERMINATE 4'h6

// Address bit for auto precharge / all banks
`define SDB_AP_BIT 10

// Burst length codes
`define SDB_BL_1 3'h0
`define SDB_BL_2 3'h1
`define SDB_BL_4 3'h2
`define SDB_BL_8 3'h3
`define SDB_BL_PAGE 3'h7

// Reset values
`define SDB_RST_BANK_OPEN 4'h0
`define SDB_RST_WORD 16'h0000

`endif

// ### dv/sdb_chk.sv
`timescale 1ns/100ps
`include "sdb_defs.vh"
module sdb_chk #(
  parameter DATA_W = 16
)
(
  // Clock and command pins
  input logic i_clk,
  input logic i_reset_n,
  input logic i_clk_en,
  input logic i_cs_n,
  input logic i_ras_n,
  input logic i_cas_n,
  input logic i_we_n,
  input logic [11:0] i_addr,
  input logic [1:0] i_bank_select_inputs,
  input logic i_dqm,
  // Data and mode
  input logic [DATA_W-1:0] i_dq,
  input logic [DATA_W-1:0] o_dq,
  input logic o_dq_oe,
  input logic i_latency_three,
  input logic [2:0] i_burst_len,
  input logic i_interleave,
  input logic i_write_burst_mode_bit,
  // Status
  input logic [3:0] o_bank_open,
  input logic o_wr_buffer_ready
);
  wire [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  wire rd = i_clk_en && cmd == `SDB_CMD_READ;
  wire wr = i_clk_en && cmd == `SDB_CMD_WRITE;
  wire idle = i_clk_en && (i_cs_n || cmd == 4'h7);
  reg [1:0] bank_q;
  reg all_q;
  always @(posedge i_clk)
  begin
    bank_q <= i_bank_select_inputs;
    all_q <= i_addr[`SDB_AP_BIT];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_flow;
    i_clk_en && !i_dqm && cmd != `SDB_CMD_WRITE;
  endsequence
  sequence s_run;
    idle && !i_dqm;
  endsequence
  sequence s_short_read;
    rd && i_burst_len == `SDB_BL_1 && !i_latency_three;
  endsequence
  a_first_word: assert property (rd && !i_latency_three && !i_dqm ##1 s_flow |=> o_dq_oe)
    else $error("read data missing at latency two");
  a_read_release: assert property (s_short_read ##1 idle [*2] |=> !o_dq_oe)
    else $error("data pins still driven after burst");
  a_page_run: assert property (rd && i_burst_len == `SDB_BL_PAGE && !i_latency_three
    ##1 s_run [*8] |=> o_dq_oe)
    else $error("full page burst stopped early");
  a_oe_cause: assert property ($rose(o_dq_oe) |->
    (i_latency_three ? $past(rd, 3) : $past(rd, 2)))
    else $error("output driven without read at latency");
  a_mask_delay: assert property (i_dqm |-> ##2 !o_dq_oe)
    else $error("mask did not silence output two clocks later");
  a_write_float: assert property (wr && $past(i_dqm) |=> !o_dq_oe)
    else $error("pins driven after truncating write");
  a_pre_close: assert property (i_clk_en && cmd == `SDB_CMD_PRECHARGE |=>
    (o_bank_open & (all_q ? 4'hf : 4'h1 << bank_q)) == 4'h0)
    else $error("precharge left bank open");
  a_auto_close: assert property ((rd || wr) && i_addr[`SDB_AP_BIT] &&
    (i_burst_len == `SDB_BL_1 || wr && i_write_burst_mode_bit) |=> !o_bank_open[bank_q])
    else $error("auto precharge left bank open");
endmodule // sdb_chk
bind sdb_core sdb_chk #(.DATA_W(DATA_W)) sdb_chk_inst (.i_clk, .i_reset_n, .i_clk_en, .i_cs_n,
  .i_ras_n, .i_cas_n, .i_we_n, .i_addr, .i_bank_select_inputs, .i_dqm, .i_dq, .o_dq, .o_dq_oe,
  .i_latency_three, .i_burst_len, .i_interleave, .i_write_burst_mode_bit, .o_bank_open,
  .o_wr_buffer_ready);

// ### dv/sdb_ctl.sv
`timescale 1ns/100ps
`include "sdb_defs.vh"
module sdb_ctl #(
  parameter ACT_DLY = 2,
  parameter WR_GAP = 2,
  parameter RP_GAP = 2
)
(
  // Clock
  input wire i_clk,
  // Command pins
  output reg o_cs_n,
  output reg o_ras_n,
  output reg o_cas_n,
  output reg o_we_n,
  output reg [11:0] o_addr,
  output reg [1:0] o_bank,
  output reg o_dqm,
  // Write data
  output reg [15:0] o_dq
);
  initial
  begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
    o_addr = 12'h000;
    o_bank = 2'h0;
    o_dqm = 1'b0;
    o_dq = 16'h0000;
  end
  // Released data toggles so a stale word never passes for valid
  task op(input [3:0] k, input [1:0] b, input [11:0] a, input m, input drv, input [15:0] d);
    begin
      @(posedge i_clk);
      #1;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = k;
      o_bank = b;
      o_addr = a;
      o_dqm = m;
      o_dq = drv ? d : ~o_dq;
    end
  endtask
  task idle(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
        op(4'h7, o_bank, 12'h000, 1'b0, 1'b0, 16'h0000);
    end
  endtask
  task act(input [1:0] b);
    begin
      op(`SDB_CMD_ACTIVATE, b, 12'h000, 1'b0, 1'b0, 16'h0000);
      idle(ACT_DLY);
    end
  endtask
  task pre(input [1:0] b);
    integer k;
    begin
      for (k = 0; k < WR_GAP; k = k + 1)
        op(4'h7, b, 12'h000, 1'b1, 1'b0, 16'h0000);
      op(`SDB_CMD_PRECHARGE, b, 12'h000, 1'b1, 1'b0, 16'h0000);
      idle(RP_GAP);
    end
  endtask
endmodule // sdb_ctl

// ### dv/tb_sdb_core.sv
`timescale 1ns/100ps
`include "sdb_defs.vh"
module tb_sdb_core;
  reg i_clk, i_reset_n, lat3, il, wbm, ap, clk_en;
  reg [2:0] blen;
  reg [1:0] b;
  reg [7:0] c;
  reg [15:0] d;
  reg [15:0] mem [0:1023];
  wire cs_n, ras_n, cas_n, we_n, dqm, dq_oe, buf_rdy;
  wire [11:0] addr;
  wire [1:0] bank;
  wire [15:0] ctl_dq, dq_out;
  wire [3:0] bank_open;
  wire [15:0] dq_wire = dq_oe ? dq_out : ctl_dq;
  integer seed, mismatches, num_checks, cyc, i, j, n, r;
  sdb_core sdb_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr),
    .i_bank_select_inputs(bank), .i_dqm(dqm), .i_dq(dq_wire), .o_dq(dq_out), .o_dq_oe(dq_oe),
    .i_latency_three(lat3), .i_burst_len(blen), .i_interleave(il),
    .i_write_burst_mode_bit(wbm), .o_bank_open(bank_open), .o_wr_buffer_ready(buf_rdy));
  sdb_ctl sdb_ctl_inst (.i_clk(i_clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_addr(addr), .o_bank(bank), .o_dqm(dqm), .o_dq(ctl_dq));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function [7:0] col_at(input [7:0] s, input [7:0] k, input w);
    reg [7:0] m;
    begin
      m = (blen == 3'h7) ? 8'hff : (8'h01 << blen) - 8'h01;
      if (w && wbm)
        m = 8'h00;
      col_at = (s & ~m) | (((il && blen != 3'h7) ? s ^ k : s + k) & m);
    end
  endfunction
  task chk_dq(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp || ^got === 1'bx)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: data %h, want %h", $time, got, exp);
      end
    end
  endtask
  task chk_flag(input got, input exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
      end
    end
  endtask
  task cmd(input [3:0] k, input [11:0] a, input m);
    sdb_ctl_inst.op(k, b, a, m, 1'b0, 16'h0000);
  endtask
  task wr(input integer len);
    for (j = 0; j < len; j = j + 1)
    begin
      d = $random(seed);
      r = j > 0 && ($random(seed) & 7) == 0;
      sdb_ctl_inst.op(j ? 4'h7 : `SDB_CMD_WRITE, b, {1'b0, ap, 2'h0, c}, r[0], 1'b1, d);
      if (!r && (j == 0 || !wbm))
        mem[{b, col_at(c, 8'(j), 1'b1)}] = d;
    end
  endtask
  task rd(input integer len, input [3:0] stop);
    begin
      n = lat3 ? 3 : 2;
      cmd(`SDB_CMD_READ, {1'b0, ap, 2'h0, c}, 1'b0);
      for (j = 0; j < n + len; j = j + 1)
      begin
        cmd(j == len - 1 ? stop : 4'h7, 12'h000, 1'b0);
        if (j >= n - 1 && j < n - 1 + len)
          chk_dq(dq_out, mem[{b, col_at(c, 8'(j - n + 1), 1'b0)}]);
        else if (j == n - 1 + len)
          chk_flag(dq_oe, 1'b0);
      end
    end
  endtask
  task reopen;
    begin
      chk_flag(bank_open[b], 1'b0);
      sdb_ctl_inst.act(b);
      chk_flag(bank_open[b], 1'b1);
    end
  endtask
  task print_verdict;
    begin
      if (mismatches == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge i_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: run hung", $time);
      print_verdict;
    end
  end
  initial
  begin
    {seed, mismatches, num_checks, cyc} = {32'd63232, 96'd0};
    {i_reset_n, lat3, il, wbm, ap, blen, b, c} = 0;
    clk_en = 1'b1;
    // Known contents on both sides, so an unwritten word cannot pass as X
    for (i = 0; i < 1024; i = i + 1)
    begin
      mem[i] = {i[7:0], 8'h5a} ^ 16'h0c33;
      sdb_core_inst.mem[i] = mem[i];
    end
    repeat (10) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    for (i = 0; i < 4; i = i + 1)
      sdb_ctl_inst.act(i[1:0]);
    for (i = 0; i < 40; i = i + 1)
    begin
      r = $random(seed);
      blen = (r[2] || i == 0) ? 3'h7 : {1'b0, r[1:0]};
      {lat3, il, wbm, b} = r[6:2];
      ap = r[7] && blen != 3'h7;
      c = i ? r[15:8] : 8'hfb;
      n = blen == 3'h7 ? 10 : 1 << blen;
      wr(n);
      if (blen == 3'h7)
        sdb_ctl_inst.op(`SDB_CMD_TERMINATE, b, 12'h000, 1'b0, 1'b1, 16'hdead);
      sdb_ctl_inst.idle(6);
      if (ap)
        reopen;
      rd(blen == 3'h7 ? 11 : n, blen == 3'h7 ? `SDB_CMD_TERMINATE : 4'h7);
      if (ap)
        reopen;
    end
    {blen, lat3, il, wbm, ap, b, c} = {`SDB_BL_4, 4'h0, 2'h1, 8'h40};
    wr(2);
    b = 2'h2;
    rd(4, 4'h7);
    sdb_ctl_inst.idle(4);
    chk_flag(buf_rdy, 1'b1);
    b = 2'h1;
    rd(4, 4'h7);
    blen = `SDB_BL_2;
    cmd(`SDB_CMD_READ, 12'h041, 1'b0);
    cmd(`SDB_CMD_READ, 12'h040, 1'b0);
    for (i = 0; i < 3; i = i + 1)
    begin
      cmd(4'h7, 12'h000, 1'b0);
      chk_dq(dq_out, mem[{b, i ? 8'h3f + i[7:0] : 8'h41}]);
    end
    blen = `SDB_BL_4;
    cmd(`SDB_CMD_READ, 12'h040, 1'b0);
    for (i = 0; i < 3; i = i + 1)
      cmd(4'h7, 12'h000, 1'b1);
    c = 8'h44;
    wr(4);
    sdb_ctl_inst.pre(b);
    chk_flag(bank_open[b], 1'b0);
    sdb_ctl_inst.act(b);
    rd(4, 4'h7);
    cmd(`SDB_CMD_READ, 12'h044, 1'b0);
    cmd(4'h7, 12'h000, 1'b0);
    cmd(4'h7, 12'h000, 1'b0);
    chk_dq(dq_out, mem[{b, 8'h44}]);
    // Frozen edges must neither advance the burst nor release the pins
    clk_en = 1'b0;
    repeat (3)
      cmd(4'h7, 12'h000, 1'b0);
    chk_dq(dq_out, mem[{b, 8'h44}]);
    chk_flag(dq_oe, 1'b1);
    clk_en = 1'b1;
    cmd(4'h7, 12'h000, 1'b0);
    chk_dq(dq_out, mem[{b, 8'h45}]);
    cmd(`SDB_CMD_PRECHARGE, 12'h400, 1'b0);
    cmd(4'h7, 12'h000, 1'b0);
    chk_flag(bank_open == 4'h0, 1'b1);
    print_verdict;
  end
endmodule // tb_sdb_core
